/* verilog/negotiation_status_pkg.sv */
// shared constants for the negotiation result and address register
package negotiation_status_pkg;

    // =========================================================================
    // register map
    localparam int          APB_ADDR_W      = 12;
    localparam int          APB_DATA_W      = 32;
    // printed offset is not a multiple of four, so it is a word index
    localparam logic [9:0]  RESULT_REG_INDEX = 10'h011;
    localparam logic [11:0] RESULT_REG_BYTE  = {RESULT_REG_INDEX, 2'b00};

    // =========================================================================
    // field layout of the 16-bit register
    localparam int REG_W          = 16;
    localparam int FAST_FDX_BIT   = 15;
    localparam int FAST_HDX_BIT   = 14;
    localparam int SLOW_FDX_BIT   = 13;
    localparam int SLOW_HDX_BIT   = 12;
    localparam int RESV_MSB       = 11;
    localparam int RESV_LSB       = 9;
    localparam int ADDR_MSB       = 8;
    localparam int ADDR_LSB       = 4;
    localparam int MON_MSB        = 3;
    localparam int MON_LSB        = 0;
    localparam int STATION_ADDR_W = 5;
    localparam int MON_W          = 4;
    localparam int RESULT_W       = 4;

    // =========================================================================
    // reset values
    localparam logic [3:0] RESULT_RESET       = 4'hf;
    localparam logic [4:0] STATION_ADDR_RESET = 5'h00;
    localparam logic [3:0] MON_RESET          = 4'h0;

    // =========================================================================
    // monitor encodings
    localparam logic [3:0] MON_IDLE      = 4'h0;
    localparam logic [3:0] MON_ABILITY   = 4'h1;
    localparam logic [3:0] MON_ACK_MATCH = 4'h2;
    localparam logic [3:0] MON_ACK_FAIL  = 4'h3;
    localparam logic [3:0] MON_CONS      = 4'h4;
    localparam logic [3:0] MON_CONS_FAIL = 4'h5;
    localparam logic [3:0] MON_PD_READY  = 4'h6;
    localparam logic [3:0] MON_PD_FAIL   = 4'h7;

    // negotiation state reported by the state machine outside this block
    typedef enum logic [2:0] {
        NEG_IDLE,
        NEG_ABILITY,
        NEG_ACK_MATCH,
        NEG_ACK_FAIL,
        NEG_CONS,
        NEG_CONS_FAIL,
        NEG_PD_READY,
        NEG_PD_FAIL
    } neg_state_type;

endpackage

/* verilog/station_addr_matcher.sv */
// serial station address comparator, most significant bit first
`timescale 1ns/1ns
module station_addr_matcher
    import negotiation_status_pkg::*;
#(
    parameter int ADDR_W = STATION_ADDR_W
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    // serial address bits from the frame
    input  wire logic              start_in,
    input  wire logic              bit_in,
    input  wire logic              bit_valid_in,
    // own address
    input  wire logic [ADDR_W-1:0] station_addr_in,
    // result
    output logic                   match_out,
    output logic                   done_out
);

    // =========================================================================
    // shift and count
    logic [ADDR_W-1:0] shift_r;
    logic [ADDR_W-1:0] shift_nxt;
    logic [2:0]        count_r;
    logic [2:0]        count_nxt;
    logic              last_bit;
    logic              take_bit;

    // first bit lands at the top after all shifts
    assign take_bit  = bit_valid_in && (count_r < 3'(ADDR_W));
    assign shift_nxt = {shift_r[ADDR_W-2:0], bit_in};
    assign count_nxt = count_r + 3'h1;
    assign last_bit  = take_bit && (count_nxt == 3'(ADDR_W));

    always_ff @(posedge clk_in) begin
        if (!nrst_in || start_in) begin
            count_r <= 3'h0;
            shift_r <= '0;
        end else if (take_bit) begin
            count_r <= count_nxt;
            shift_r <= shift_nxt;
        end
    end

    // =========================================================================
    // one-cycle verdict after the fifth bit
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            match_out <= 1'b0;
            done_out  <= 1'b0;
        end else begin
            done_out  <= last_bit;
            match_out <= last_bit && (shift_nxt == station_addr_in);
        end
    end

endmodule

/* verilog/negotiation_status_reg.sv */
// negotiation result, station address and monitor register behind apb
//
// Summary of operation
// - on negotiation done, bit 15 is set when the resolved mode is 100 Mbps full duplex.
// - on negotiation done, bit 14 is set when the resolved mode is 100 Mbps half duplex.
// - on negotiation done, bit 13 is set when the resolved mode is 10 Mbps full duplex.
// - on negotiation done, bit 12 is set when the resolved mode is 10 Mbps half duplex.
// - bits 15 to 12 reset to one and mean nothing outside negotiation mode.
// - bits 11 to 9 read as zero and writes to them are dropped.
// - the station address travels in frames most significant bit first.
// - bits 3 to 0 follow the live negotiation state, read only, reset to zero.
// - monitor codes: 0 idle, 2/3 ack match/fail, 4/5 consistency/fail, 6/7 pd ready/fail.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module negotiation_status_reg
    import negotiation_status_pkg::*;
(
    // clock and reset
    input  wire logic                  CLK_IN,
    input  wire logic                  NRST_IN,
    // apb slave
    input  wire logic                  PSEL_IN,
    input  wire logic                  PENABLE_IN,
    input  wire logic                  PWRITE_IN,
    input  wire logic [APB_ADDR_W-1:0] PADDR_IN,
    input  wire logic [APB_DATA_W-1:0] PWDATA_IN,
    input  wire logic [3:0]            PSTRB_IN,
    output logic [APB_DATA_W-1:0]      PRDATA_OUT,
    output logic                       PREADY_OUT,
    output logic                       PSLVERR_OUT,
    // negotiation engine
    input  wire logic                  NEG_MODE_IN,
    input  wire logic                  NEG_DONE_IN,
    input  wire logic                  NEG_SPEED_FAST_IN,
    input  wire logic                  NEG_FULL_DUPLEX_IN,
    input  wire logic [2:0]            NEG_STATE_IN,
    // address strap
    input  wire logic [4:0]            CFG_STATION_ADDR_IN,
    // management frame address bits
    input  wire logic                  FRAME_START_IN,
    input  wire logic                  FRAME_ADDR_BIT_IN,
    input  wire logic                  FRAME_ADDR_VALID_IN,
    // results to the phy
    output logic [4:0]                 STATION_ADDR_OUT,
    output logic                       ADDR_MATCH_OUT,
    output logic                       ADDR_CHECKED_OUT,
    output logic [3:0]                 RESULT_FLAGS_OUT,
    output logic                       NEG_RESULT_VALID_OUT
);

    // =========================================================================
    // helpers

    // one-hot result from speed and duplex
    function automatic logic [3:0] mode_flags(input logic fast, input logic fdx);
        logic [3:0] f;
        f = 4'h0;
        case ({fast, fdx})
            2'b11:   f = 4'h8;
            2'b10:   f = 4'h4;
            2'b01:   f = 4'h2;
            default: f = 4'h1;
        endcase
        return f;
    endfunction

    // state index to monitor code
    function automatic logic [3:0] monitor_code(input logic [2:0] st);
        logic [3:0] c;
        c = MON_IDLE;
        case (neg_state_type'(st))
            NEG_IDLE:      c = MON_IDLE;
            NEG_ABILITY:   c = MON_ABILITY;
            NEG_ACK_MATCH: c = MON_ACK_MATCH;
            NEG_ACK_FAIL:  c = MON_ACK_FAIL;
            NEG_CONS:      c = MON_CONS;
            NEG_CONS_FAIL: c = MON_CONS_FAIL;
            NEG_PD_READY:  c = MON_PD_READY;
            NEG_PD_FAIL:   c = MON_PD_FAIL;
            default:       c = MON_IDLE;
        endcase
        return c;
    endfunction

    // =========================================================================
    // apb decode
    logic                  setup_phase;
    logic                  access_phase;
    logic                  transfer_done;
    logic                  reg_hit;
    logic                  wr_commit;
    logic                  wr_addr_lo;
    logic                  wr_addr_hi;
    logic [APB_DATA_W-1:0] read_word;
    logic                  pready_r;
    logic                  pslverr_r;
    logic [APB_DATA_W-1:0] prdata_r;

    assign setup_phase   = PSEL_IN && !PENABLE_IN;
    assign access_phase  = PSEL_IN && PENABLE_IN;
    // the request completes at the edge where our ready is seen high
    assign transfer_done = access_phase && pready_r;
    assign reg_hit       = (PADDR_IN == RESULT_REG_BYTE);
    assign wr_commit     = transfer_done && PWRITE_IN && reg_hit;
    // bit 8 lives in byte lane 1, bits 7..4 in lane 0
    assign wr_addr_hi    = wr_commit && PSTRB_IN[1];
    assign wr_addr_lo    = wr_commit && PSTRB_IN[0];

    // =========================================================================
    // one wait state: ready rises at the end of the first access cycle, high in the second
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= access_phase && !pready_r;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= access_phase && !pready_r && !reg_hit;
        end
    end

    // =========================================================================
    // station address with strap capture after reset release
    logic [4:0] station_addr_r;
    logic [4:0] station_addr_nxt;
    logic       strap_loaded_r;

    // strap is a plain level, so it is taken by a clocked load, not by the reset
    always_comb begin
        station_addr_nxt = station_addr_r;
        if (!strap_loaded_r) begin
            station_addr_nxt = CFG_STATION_ADDR_IN;
        end else begin
            if (wr_addr_hi) begin
                station_addr_nxt[4] = PWDATA_IN[ADDR_MSB];
            end
            if (wr_addr_lo) begin
                station_addr_nxt[3:0] = PWDATA_IN[ADDR_MSB-1:ADDR_LSB];
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            strap_loaded_r <= 1'b0;
        end else begin
            strap_loaded_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            station_addr_r <= STATION_ADDR_RESET;
        end else begin
            station_addr_r <= station_addr_nxt;
        end
    end

    // =========================================================================
    // negotiation result flags
    logic [3:0] result_r;
    logic [3:0] result_nxt;
    logic       result_valid_r;

    // read only: software writes never touch the flags
    assign result_nxt = NEG_DONE_IN ?
                        mode_flags(NEG_SPEED_FAST_IN, NEG_FULL_DUPLEX_IN) : result_r;

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            result_r <= RESULT_RESET;
        end else begin
            result_r <= result_nxt;
        end
    end

    // flags are only trustworthy after a completed negotiation in that mode
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN || !NEG_MODE_IN) begin
            result_valid_r <= 1'b0;
        end else if (NEG_DONE_IN) begin
            result_valid_r <= 1'b1;
        end
    end

    // =========================================================================
    // live monitor of the negotiation state
    logic [3:0] monitor_r;

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            monitor_r <= MON_RESET;
        end else begin
            monitor_r <= monitor_code(NEG_STATE_IN);
        end
    end

    // =========================================================================
    // read data
    logic [REG_W-1:0] reg_value;

    assign reg_value = {result_r,
                        3'h0,
                        station_addr_r,
                        monitor_r};
    // unmapped addresses read as zero and flag an error
    assign read_word = reg_hit ? {{(APB_DATA_W-REG_W){1'b0}}, reg_value} : '0;

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            prdata_r <= '0;
        end else if (access_phase && !pready_r && !PWRITE_IN) begin
            prdata_r <= read_word;
        end
    end

    // =========================================================================
    // frame address comparison against our own address
    logic match_w;
    logic checked_w;

    station_addr_matcher #(
        .ADDR_W          (STATION_ADDR_W)
    ) u_matcher (
        .clk_in          (CLK_IN),
        .nrst_in         (NRST_IN),
        .start_in        (FRAME_START_IN),
        .bit_in          (FRAME_ADDR_BIT_IN),
        .bit_valid_in    (FRAME_ADDR_VALID_IN),
        .station_addr_in (station_addr_r),
        .match_out       (match_w),
        .done_out        (checked_w)
    );

    // =========================================================================
    // outputs
    assign PRDATA_OUT           = prdata_r;
    assign PREADY_OUT           = pready_r;
    assign PSLVERR_OUT          = pslverr_r;
    assign STATION_ADDR_OUT     = station_addr_r;
    assign ADDR_MATCH_OUT       = match_w;
    assign ADDR_CHECKED_OUT     = checked_w;
    assign RESULT_FLAGS_OUT     = result_r;
    assign NEG_RESULT_VALID_OUT = result_valid_r;

endmodule

/* verification/negotiation_status_reg_assertions.sv */
// concurrent checks on the negotiation result register ports
`timescale 1ns/1ns
module negotiation_status_reg_checker
    import negotiation_status_pkg::*;
(
    // clock and reset
    input wire logic        CLK_IN,
    input wire logic        NRST_IN,
    // apb slave
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0]  PSTRB_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    // negotiation engine
    input wire logic        NEG_DONE_IN,
    input wire logic        NEG_SPEED_FAST_IN,
    input wire logic        NEG_FULL_DUPLEX_IN,
    // outputs
    input wire logic [4:0]  STATION_ADDR_OUT,
    input wire logic        ADDR_MATCH_OUT,
    input wire logic        ADDR_CHECKED_OUT,
    input wire logic [3:0]  RESULT_FLAGS_OUT
);
    // =====================================
    // helpers
    wire logic [4:0] wr_addr = PWDATA_IN[8:4];
    wire logic       wr_ok   = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT && !PSLVERR_OUT;
    wire logic       done_f  = NEG_DONE_IN && NEG_SPEED_FAST_IN;
    wire logic       done_s  = NEG_DONE_IN && !NEG_SPEED_FAST_IN;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // =====================================
    // properties
    property p_fast_full;
        done_f && NEG_FULL_DUPLEX_IN |=> RESULT_FLAGS_OUT == 4'h8;
    endproperty
    a_fast_full: assert property (p_fast_full) else $error("fast full flag wrong");
    property p_fast_half;
        done_f && !NEG_FULL_DUPLEX_IN |=> RESULT_FLAGS_OUT == 4'h4;
    endproperty
    a_fast_half: assert property (p_fast_half) else $error("fast half flag wrong");
    property p_slow_full;
        done_s && NEG_FULL_DUPLEX_IN |=> RESULT_FLAGS_OUT == 4'h2;
    endproperty
    a_slow_full: assert property (p_slow_full) else $error("slow full flag wrong");
    property p_slow_half;
        done_s && !NEG_FULL_DUPLEX_IN |=> RESULT_FLAGS_OUT == 4'h1;
    endproperty
    a_slow_half: assert property (p_slow_half) else $error("slow half flag wrong");
    // flags only move on a completed negotiation
    property p_flags_hold;
        !NEG_DONE_IN |=> $stable(RESULT_FLAGS_OUT);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved");
    property p_resv_zero;
        PREADY_OUT |-> PRDATA_OUT[31:16] == 16'h0 && PRDATA_OUT[11:9] == 3'h0;
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("reserved bits set");
    property p_addr_write;
        wr_ok && PADDR_IN == RESULT_REG_BYTE && PSTRB_IN[1:0] == 2'h3
            |=> STATION_ADDR_OUT == $past(wr_addr);
    endproperty
    a_addr_write: assert property (p_addr_write) else $error("address not written");
    property p_match_checked;
        ADDR_MATCH_OUT |-> ADDR_CHECKED_OUT;
    endproperty
    a_match_checked: assert property (p_match_checked) else $error("stray match");
    // the checked verdict must be a one-cycle pulse, never high two cycles running
    property p_checked_pulse;
        ADDR_CHECKED_OUT |=> !ADDR_CHECKED_OUT;
    endproperty
    a_checked_pulse: assert property (p_checked_pulse) else $error("checked not a pulse");
endmodule

/* verification/smi_manager_model.sv */
// station management model that shifts a device address into frames
`timescale 1ns/1ns
module smi_manager_model (
    // clock
    input  wire logic clk_in,
    // frame address lines
    output logic      start_out,
    output logic      bit_out,
    output logic      valid_out
);
    initial begin
        start_out = 1'b0;
        bit_out   = 1'b0;
        valid_out = 1'b0;
    end
    // every access names its target by address, msb first
    task automatic send(input logic [4:0] a, input int gap);
        @(posedge clk_in);
        start_out <= 1'b1;
        @(posedge clk_in);
        start_out <= 1'b0;
        for (int i = 4; i >= 0; i--) begin
            bit_out   <= a[i];
            valid_out <= 1'b1;
            @(posedge clk_in);
            if (gap > 0 && i > 0) begin
                valid_out <= 1'b0;
                bit_out   <= ~a[i];
                repeat (gap) @(posedge clk_in);
            end
        end
        // released line shows no stale bit
        valid_out <= 1'b0;
        bit_out   <= ~a[0];
    endtask
endmodule

/* verification/negotiation_status_reg_test.sv */
// self-checking bench for the negotiation result register
`timescale 1ns/1ns
module negotiation_status_reg_test;
    import negotiation_status_pkg::*;
    // =====================================
    // signals
    logic        clk, nrst, psel, penable, pwrite, mode, done, fast, fdx;
    logic        pready, pslverr, err, fstart, fbit, fvalid, match, checked, rvalid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0]  pstrb, flags, ef, ps;
    logic [2:0]  state;
    logic [4:0]  strap, addr, sta, fa;
    int          fails, total_checks, n;
    negotiation_status_reg negotiation_status_reg_i (
        .CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .NEG_MODE_IN(mode), .NEG_DONE_IN(done), .NEG_SPEED_FAST_IN(fast),
        .NEG_FULL_DUPLEX_IN(fdx), .NEG_STATE_IN(state), .CFG_STATION_ADDR_IN(strap),
        .FRAME_START_IN(fstart), .FRAME_ADDR_BIT_IN(fbit), .FRAME_ADDR_VALID_IN(fvalid),
        .STATION_ADDR_OUT(sta), .ADDR_MATCH_OUT(match), .ADDR_CHECKED_OUT(checked),
        .RESULT_FLAGS_OUT(flags), .NEG_RESULT_VALID_OUT(rvalid));
    smi_manager_model smi_manager_model_i (.clk_in(clk), .start_out(fstart),
        .bit_out(fbit), .valid_out(fvalid));
    // =====================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic [3:0] flag_exp(input logic f, input logic d);
        return f ? (d ? 4'h8 : 4'h4) : (d ? 4'h2 : 4'h1);
    endfunction
    task automatic complete_run();
        if (fails == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    // one idle edge first, so a release never meets a new setup in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            complete_run();
        end
    endtask
    task automatic rd_word(input string what);
        apb(1'b0, RESULT_REG_BYTE, 32'h0, 4'h0);
        cmp(what, {16'h0, ef, 3'h0, addr, 1'b0, state}, rd);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // =====================================
    // main sequence
    initial begin
        seed = 32'h8079dbe8;
        fails = 0;
        total_checks = 0;
        {nrst, psel, penable, pwrite, done, fast, fdx} = 7'h0;
        {paddr, pwdata, pstrb, state} = '0;
        mode = 1'b1;
        strap = seed[8:4];
        addr = strap;
        ef = 4'hf;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd_word("reset word");
        for (int i = 0; i < 8; i++) begin
            state <= i[2:0];
            @(posedge clk);
            rd_word("monitor");
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            fast <= (i < 4) ? i[1] : seed[0];
            fdx  <= (i < 4) ? i[0] : seed[1];
            done <= 1'b1;
            @(posedge clk);
            ef = flag_exp(fast, fdx);
            done <= 1'b0;
            fast <= ~fast;
            @(posedge clk);
            cmp("flags", {28'h0, ef}, {28'h0, flags});
            rd_word("flag word");
        end
        cmp("result valid", 32'h1, {31'h0, rvalid});
        // leaving negotiation mode voids the flags but keeps their last value
        mode <= 1'b0;
        repeat (2) @(posedge clk);
        cmp("valid out of mode", 32'h0, {31'h0, rvalid});
        cmp("flags out of mode", {28'h0, ef}, {28'h0, flags});
        mode <= 1'b1;
        done <= 1'b1;
        @(posedge clk);
        ef = flag_exp(fast, fdx);
        done <= 1'b0;
        @(posedge clk);
        cmp("valid in mode", 32'h1, {31'h0, rvalid});
        cmp("flags in mode", {28'h0, ef}, {28'h0, flags});
        // lane cases first, then full random words with reserved bits set
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            state <= seed[14:12];
            ps = (i == 0) ? 4'h1 : (i == 1) ? 4'h2 : 4'hf;
            apb(1'b1, RESULT_REG_BYTE, seed | 32'h0000fe0f, ps);
            addr = {ps[1] ? seed[8] : addr[4], ps[0] ? seed[7:4] : addr[3:0]};
            @(posedge clk);
            cmp("station addr", {27'h0, addr}, {27'h0, sta});
            rd_word("readback");
        end
        apb(1'b1, RESULT_REG_BYTE + 12'h4, 32'hffffffff, 4'hf);
        cmp("write err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h040, 32'h0, 4'h0);
        cmp("read err", 32'h1, {31'h0, err});
        cmp("err data", 32'h0, rd);
        rd_word("after unmapped");
        // mid-run reset with a new strap: flags, validity and address start over
        nrst  <= 1'b0;
        strap <= ~strap;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        addr = strap;
        ef   = 4'hf;
        rd_word("second reset word");
        cmp("valid after reset", 32'h0, {31'h0, rvalid});
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            fa = (i == 0) ? addr ^ 5'h10 : (i == 1) ? addr : (i == 2) ? addr ^ 5'h01 : seed[4:0];
            smi_manager_model_i.send(fa, i);
            n = 0;
            while (checked !== 1'b1 && n < 20) begin
                @(posedge clk);
                n++;
            end
            if (n >= 20) begin
                fails++;
                complete_run();
            end
            cmp("match", {31'h0, fa == addr}, {31'h0, match});
        end
        complete_run();
    end
endmodule
bind negotiation_status_reg negotiation_status_reg_checker chk_i (
    .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .NEG_DONE_IN(NEG_DONE_IN), .NEG_SPEED_FAST_IN(NEG_SPEED_FAST_IN),
    .NEG_FULL_DUPLEX_IN(NEG_FULL_DUPLEX_IN), .STATION_ADDR_OUT(STATION_ADDR_OUT),
    .ADDR_MATCH_OUT(ADDR_MATCH_OUT), .ADDR_CHECKED_OUT(ADDR_CHECKED_OUT),
    .RESULT_FLAGS_OUT(RESULT_FLAGS_OUT));
